// ---- hdl/alarm_cfg.svh ----
`ifndef ALARM_CFG_SVH
`define ALARM_CFG_SVH

// Threshold word width, hundredths of a dBm, two's complement.
`define PWR_W 16
`define MAX_CH 4

// Threshold range and reset values: +100.00 and -100.00 dBm.
`define THR_MAX 16'h2710
`define THR_MIN 16'hd8f0
`define UPPER_RST 16'h2710
`define LOWER_RST 16'hd8f0

// Address map.
`define ADDR_W 8
`define CH_REG_PAGE 2'h0
`define REG_UPPER 2'h0
`define REG_LOWER 2'h1
`define REG_CTRL 2'h2
`define REG_FLAGS 2'h3
`define REG_IRQ_STATUS 8'h10
`define REG_IRQ_MASK 8'h11
`define TEXT_PAGE 2'h1
`define TEXT_LEN 4'h9

// Control register fields.
`define CTRL_ENABLE 0
`define CTRL_CLEAR 1

// Flag vector positions, in reporting order from the top.
`define FLAG_ANY 4
`define FLAG_UNDER_NOW 3
`define FLAG_OVER_NOW 2
`define FLAG_LOW_LAT 1
`define FLAG_HIGH_LAT 0
`define FLAGS_W 5

// Characters of the status text.
`define CHAR_ZERO 8'h30
`define CHAR_ONE 8'h31
`define CHAR_COMMA 8'h2c
`define CHAR_NONE 8'h00

`endif

// ---- hdl/alarm_pkg.sv ----
`include "alarm_cfg.svh"

package alarm_pkg;

    typedef struct packed {
        logic under_low_now;
        logic over_high_now;
        logic low_violation_latched;
        logic high_violation_latched;
    } chan_state_t;

    typedef struct packed {
        logic [`MAX_CH-1:0] en;
        logic [`MAX_CH-1:0][`PWR_W-1:0] upper;
        logic [`MAX_CH-1:0][`PWR_W-1:0] lower;
        logic [2*`MAX_CH-1:0] irq_status;
        logic [2*`MAX_CH-1:0] irq_mask;
        logic [`PWR_W-1:0] rdata;
    } top_state_t;

    // A threshold outside the allowed span is refused and the old value kept.
    function automatic logic thr_in_range(input logic [`PWR_W-1:0] v);
        thr_in_range = ($signed(v) <= $signed(`THR_MAX)) && ($signed(v) >= $signed(`THR_MIN));
    endfunction

    function automatic logic chan_reg_hit(input logic [`ADDR_W-1:0] a, input logic [1:0] ch,
                                          input logic [1:0] r);
        chan_reg_hit = (a[7:4] == {2'h0, `CH_REG_PAGE}) && (a[3:2] == ch) && (a[1:0] == r);
    endfunction

endpackage

// ---- hdl/limit_channel.sv ----
`include "alarm_cfg.svh"

module limit_channel
    import alarm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic enable,
    input wire logic [`PWR_W-1:0] upper,
    input wire logic [`PWR_W-1:0] lower,
    input wire logic [`PWR_W-1:0] avg_power,
    input wire logic power_valid,
    input wire logic clear,
    output logic [`FLAGS_W-1:0] flags,
    output logic hit_low,
    output logic hit_high
);

    chan_state_t s_q;
    chan_state_t s_d;
    logic sample;
    logic below;
    logic above;

    always_comb begin
        s_d = s_q;
        sample = enable && power_valid; // RULE_05 RULE_06
        below = $signed(avg_power) < $signed(lower);
        above = $signed(avg_power) > $signed(upper);
        if (clear) begin
            s_d.low_violation_latched = 1'b0; // RULE_11
            s_d.high_violation_latched = 1'b0; // RULE_11
        end
        // A violation in the clearing cycle still latches: the set wins.
        if (sample) begin
            s_d.under_low_now = below; // RULE_04 RULE_09
            s_d.over_high_now = above; // RULE_03 RULE_09
            if (below) begin
                s_d.low_violation_latched = 1'b1; // RULE_09
            end
            if (above) begin
                s_d.high_violation_latched = 1'b1; // RULE_09
            end
        end
        hit_low = sample && below;
        hit_high = sample && above;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    always_comb begin
        flags = '0;
        flags[`FLAG_ANY] = s_q.low_violation_latched | s_q.high_violation_latched; // RULE_12
        flags[`FLAG_UNDER_NOW] = s_q.under_low_now;
        flags[`FLAG_OVER_NOW] = s_q.over_high_now;
        flags[`FLAG_LOW_LAT] = s_q.low_violation_latched;
        flags[`FLAG_HIGH_LAT] = s_q.high_violation_latched;
    end

endmodule // limit_channel

// ---- hdl/flag_text.sv ----
`include "alarm_cfg.svh"

module flag_text
    import alarm_pkg::*;
(
    input wire logic [`FLAGS_W-1:0] flags,
    input wire logic [3:0] idx,
    output logic [7:0] character
);

    logic [2:0] pos;

    // Even positions carry a flag digit, odd ones a comma, nine characters in all.
    always_comb begin
        pos = 3'(idx >> 1);
        character = `CHAR_NONE;
        if (idx < `TEXT_LEN) begin
            if (idx[0]) begin
                character = `CHAR_COMMA; // RULE_07
            end else begin
                character = flags[3'(`FLAG_ANY) - pos] ? `CHAR_ONE : `CHAR_ZERO; // RULE_07 RULE_08
            end
        end
    end

endmodule // flag_text

// ---- hdl/power_limit_alarm.sv ----
// Function
// RULE_01: Each channel holds a readable, writable upper threshold, -100.00 to +100.00 dBm.
// RULE_02: Each channel holds a readable, writable lower threshold over the same range.
// RULE_03: Power above upper threshold sets the above flag and the up indicator.
// RULE_04: Power below lower threshold sets the below flag and the down indicator.
// RULE_05: With alarms enabled, power is compared with both thresholds and flags set.
// RULE_06: With alarms disabled, nothing happens and all flags hold their value; a clear or measurement start still zeroes the latched flags.
// RULE_07: Status query returns five comma-separated values, 1 active and 0 normal.
// RULE_08: Order is any, below now, above now, low latched, high latched.
// RULE_09: Three flags latch violations since measurement start; two follow present state.
// RULE_10: Host uses these commands only in continuous wave or modulated mode.
// RULE_11: Clear zeroes the channel's latched flags; present flags keep tracking.
// RULE_12: The any flag is the OR of both latched violation flags.
//
// Added by the designer: the placing of the registers and the plain strobed port.
`include "alarm_cfg.svh"

module power_limit_alarm
    import alarm_pkg::*;
#(
    parameter int NUM_CH = 2
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [`ADDR_W-1:0] addr,
    input wire logic [`PWR_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [`PWR_W-1:0] rdata,
    input wire logic [NUM_CH-1:0][`PWR_W-1:0] avg_power,
    input wire logic [NUM_CH-1:0] power_valid,
    input wire logic [NUM_CH-1:0] meas_start,
    output logic [NUM_CH-1:0] up_arrow,
    output logic [NUM_CH-1:0] down_arrow,
    output logic irq
);

    if (NUM_CH < 1 || NUM_CH > `MAX_CH) begin : g_bad_num_ch
        $error("NUM_CH must lie between one and the address map's channel count");
    end

    top_state_t s_q;
    top_state_t s_d;
    logic [`MAX_CH-1:0][`FLAGS_W-1:0] flags_w;
    logic [2*`MAX_CH-1:0] events;
    logic [`MAX_CH-1:0] clear_w;
    logic [7:0] text_char;
    logic [1:0] text_ch;

    // The host is trusted to stay in a valid measurement mode; no mode input is checked.
    for (genvar c = 0; c < `MAX_CH; c++) begin : g_ch
        if (c < NUM_CH) begin : g_used
            assign clear_w[c] = meas_start[c] ||
                (wr && chan_reg_hit(addr, 2'(c), `REG_CTRL) && wdata[`CTRL_CLEAR]); // RULE_11
            limit_channel u_chan (
                .clk_sys(clk_sys),
                .rst_b(rst_b),
                .enable(s_q.en[c]),
                .upper(s_q.upper[c]),
                .lower(s_q.lower[c]),
                .avg_power(avg_power[c]),
                .power_valid(power_valid[c]),
                .clear(clear_w[c]),
                .flags(flags_w[c]),
                .hit_low(events[2*c]),
                .hit_high(events[2*c+1])
            );
            assign up_arrow[c] = flags_w[c][`FLAG_OVER_NOW]; // RULE_03
            assign down_arrow[c] = flags_w[c][`FLAG_UNDER_NOW]; // RULE_04
        end else begin : g_unused
            assign clear_w[c] = 1'b0;
            assign flags_w[c] = '0;
            assign events[2*c] = 1'b0;
            assign events[2*c+1] = 1'b0;
        end
    end

    assign text_ch = addr[5:4];

    flag_text u_text (
        .flags(flags_w[text_ch]),
        .idx(addr[3:0]),
        .character(text_char)
    );

    always_comb begin
        s_d = s_q;
        s_d.rdata = '0;
        for (int c = 0; c < NUM_CH; c++) begin
            if (wr && chan_reg_hit(addr, 2'(c), `REG_UPPER) && thr_in_range(wdata)) begin
                s_d.upper[c] = wdata; // RULE_01
            end
            if (wr && chan_reg_hit(addr, 2'(c), `REG_LOWER) && thr_in_range(wdata)) begin
                s_d.lower[c] = wdata; // RULE_02
            end
            if (wr && chan_reg_hit(addr, 2'(c), `REG_CTRL)) begin
                s_d.en[c] = wdata[`CTRL_ENABLE]; // RULE_05 RULE_06
            end
            if (rd && chan_reg_hit(addr, 2'(c), `REG_UPPER)) begin
                s_d.rdata = s_q.upper[c]; // RULE_01
            end
            if (rd && chan_reg_hit(addr, 2'(c), `REG_LOWER)) begin
                s_d.rdata = s_q.lower[c]; // RULE_02
            end
            if (rd && chan_reg_hit(addr, 2'(c), `REG_CTRL)) begin
                s_d.rdata[`CTRL_ENABLE] = s_q.en[c];
            end
            if (rd && chan_reg_hit(addr, 2'(c), `REG_FLAGS)) begin
                s_d.rdata[`FLAGS_W-1:0] = flags_w[c]; // RULE_08
            end
        end
        // Write-one-to-clear; an event in the same cycle keeps its bit set.
        if (wr && addr == `REG_IRQ_STATUS) begin
            s_d.irq_status = s_q.irq_status & ~wdata[2*`MAX_CH-1:0];
        end
        s_d.irq_status = s_d.irq_status | events;
        if (wr && addr == `REG_IRQ_MASK) begin
            s_d.irq_mask = wdata[2*`MAX_CH-1:0];
        end
        if (rd && addr == `REG_IRQ_STATUS) begin
            s_d.rdata[2*`MAX_CH-1:0] = s_q.irq_status;
        end
        if (rd && addr == `REG_IRQ_MASK) begin
            s_d.rdata[2*`MAX_CH-1:0] = s_q.irq_mask;
        end
        if (rd && addr[7:6] == `TEXT_PAGE && 32'(text_ch) < NUM_CH) begin
            s_d.rdata[7:0] = text_char; // RULE_07
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s_q.en <= '0;
            s_q.upper <= {`MAX_CH{`UPPER_RST}};
            s_q.lower <= {`MAX_CH{`LOWER_RST}};
            s_q.irq_status <= '0;
            s_q.irq_mask <= '0;
            s_q.rdata <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata = s_q.rdata;
    assign irq = |(s_q.irq_status & s_q.irq_mask);

endmodule // power_limit_alarm

// ---- sim/power_limit_alarm_asserts.sv ----
`include "alarm_cfg.svh"
module power_limit_alarm_asserts
    import alarm_pkg::*;
#(
    parameter int NUM_CH = 2
) (
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic [`ADDR_W-1:0] addr,
    input wire logic [`PWR_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [`PWR_W-1:0] rdata,
    input wire logic [NUM_CH-1:0][`PWR_W-1:0] avg_power,
    input wire logic [NUM_CH-1:0] power_valid,
    input wire logic [NUM_CH-1:0] meas_start,
    input wire logic [NUM_CH-1:0] up_arrow,
    input wire logic [NUM_CH-1:0] down_arrow,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sequence s_flag_read;
        rd && addr == 8'h03;
    endsequence
    a_rdata_idle: assert property (!rd |=> rdata == '0)
        else $error("read data outside read slot");
    a_any_or: assert property (s_flag_read |=> rdata[4] == (rdata[1] | rdata[0]))
        else $error("any flag differs from latched flags");
    a_now_bits: assert property (s_flag_read |=>
        rdata[3:2] == {$past(down_arrow[0]), $past(up_arrow[0])})
        else $error("present flags differ from arrows");
    a_up_hold: assert property (1 |=> ((up_arrow ^ $past(up_arrow)) & ~$past(power_valid)) == '0)
        else $error("up arrow moved without sample");
    a_down_hold: assert property (1 |=> ((down_arrow ^ $past(down_arrow)) & ~$past(power_valid)) == '0)
        else $error("down arrow moved without sample");
    a_irq_rise: assert property ($rose(irq) |-> $past(power_valid) != '0 || $past(wr))
        else $error("interrupt rose without cause");
    a_irq_fall: assert property ($fell(irq) |-> $past(wr))
        else $error("interrupt fell without write");
    a_text_comma: assert property (rd && addr == 8'h41 |=> rdata == 16'h002c)
        else $error("separator character wrong");
    a_text_digit: assert property (rd && addr == 8'h40 |=> rdata[15:1] == 15'h0018)
        else $error("flag character not a digit");
endmodule // power_limit_alarm_asserts
bind power_limit_alarm power_limit_alarm_asserts #(.NUM_CH(NUM_CH)) chk_i (.clk_sys, .rst_b,
    .addr, .wdata, .wr, .rd, .rdata, .avg_power, .power_valid, .meas_start, .up_arrow,
    .down_arrow, .irq);

// ---- sim/alarm_host.sv ----
`include "alarm_cfg.svh"
module alarm_host (
    input wire logic clk_sys,
    input wire logic [`PWR_W-1:0] rdata,
    output logic [`ADDR_W-1:0] addr,
    output logic [`PWR_W-1:0] wdata,
    output logic wr,
    output logic rd
);
    timeunit 1ns;
    timeprecision 1ns;
    // The host never leaves continuous wave mode, so every command is legal.
    initial begin
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
    end
    task automatic write_reg(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk_sys);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk_sys);
        wr <= 1'b0;
        wdata <= ~v;
    endtask
    // Data is taken mid-cycle because it only stands in the cycle after the strobe.
    task automatic read_reg(input logic [7:0] a, output logic [15:0] v);
        @(posedge clk_sys);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk_sys);
        rd <= 1'b0;
        @(negedge clk_sys);
        v = rdata;
    endtask
endmodule // alarm_host

// ---- sim/power_limit_alarm_tb.sv ----
`include "alarm_cfg.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
    $display("unexpected %s exp %h got %h", n, e, g); end end
module power_limit_alarm_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [1:0][15:0] avg_power = '0;
    logic [1:0] power_valid = '0;
    logic [1:0] meas_start = '0;
    logic [7:0] addr;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [15:0] d;
    logic wr;
    logic rd;
    logic irq;
    logic [1:0] up_arrow;
    logic [1:0] down_arrow;
    int n_errors = 0;
    int checked = 0;
    always #10 clk_sys = ~clk_sys;
    alarm_host alarm_host_i (.clk_sys, .rdata, .addr, .wdata, .wr, .rd);
    power_limit_alarm power_limit_alarm_i (.clk_sys, .rst_b, .addr, .wdata, .wr, .rd, .rdata,
        .avg_power, .power_valid, .meas_start, .up_arrow, .down_arrow, .irq);
    task automatic wreg(input logic [7:0] a, input logic [15:0] v);
        alarm_host_i.write_reg(a, v);
        @(negedge clk_sys);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [15:0] e);
        alarm_host_i.read_reg(a, d);
        `CHK("register", e, d)
    endtask
    task automatic sample(input int c, input logic [15:0] p);
        @(posedge clk_sys);
        power_valid[c] <= 1'b1;
        avg_power[c] <= p;
        @(posedge clk_sys);
        power_valid[c] <= 1'b0;
        avg_power[c] <= ~p;
        @(negedge clk_sys);
    endtask
    task automatic t_thresholds();
        rchk(8'h00, `UPPER_RST);
        rchk(8'h05, `LOWER_RST);
        rchk(8'h08, 16'h0000);
        wreg(8'h04, 16'h03e8);
        wreg(8'h04, 16'h2711);
        rchk(8'h04, 16'h03e8);
        wreg(8'h05, 16'hd8f1);
        wreg(8'h05, 16'hd8ef);
        rchk(8'h05, 16'hd8f1);
        sample(0, 16'h2711);
        rchk(8'h03, 16'h0000);
    endtask
    task automatic t_alarm();
        logic [4:0] fl;
        fl = 5'b10011;
        wreg(8'h11, 16'h0003);
        wreg(8'h02, 16'h0001);
        sample(0, 16'h2710);
        rchk(8'h03, 16'h0000);
        sample(0, 16'h2711);
        `CHK("up_arrow", 2'b01, up_arrow)
        `CHK("irq", 1'b1, irq)
        sample(0, 16'hd8ef);
        `CHK("down_arrow", 2'b01, down_arrow)
        rchk(8'h03, 16'h001b);
        sample(0, 16'h0000);
        for (int i = 0; i < 9; i++) begin
            rchk(8'h40 + 8'(i), i[0] ? 16'h002c : (fl[4 - i / 2] ? 16'h0031 : 16'h0030));
        end
        wreg(8'h02, 16'h0003);
        rchk(8'h02, 16'h0001);
        rchk(8'h03, 16'h0000);
        wreg(8'h10, 16'h0003);
        `CHK("irq", 1'b0, irq)
    endtask
    // Channel one is masked out, so its event must not reach the interrupt line.
    task automatic t_restart();
        wreg(8'h06, 16'h0001);
        sample(1, 16'h8000);
        @(posedge clk_sys);
        meas_start[1] <= 1'b1;
        @(posedge clk_sys);
        meas_start[1] <= 1'b0;
        rchk(8'h07, 16'h0008);
        `CHK("irq", 1'b0, irq)
        rchk(8'h10, 16'h0004);
        wreg(8'h06, 16'h0000);
        sample(1, 16'h0000);
        rchk(8'h07, 16'h0008);
    endtask
    // A reset in mid-run must drop the down indicators and restore the upper threshold.
    task automatic t_reset();
        @(posedge clk_sys);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk_sys);
        `CHK("down_arrow", 2'b00, down_arrow)
        rst_b <= 1'b1;
        rchk(8'h04, `UPPER_RST);
    endtask
    task automatic final_report();
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        t_thresholds();
        t_alarm();
        t_restart();
        t_reset();
        final_report();
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        n_errors++;
        final_report();
    end
endmodule // power_limit_alarm_tb
